// ### core/dccr_consts.vh
// Register map, field positions and reset values of the config/control bank.
// Included by the bank and its unlock helper; definitions only.
`ifndef DCCR_CONSTS_VH
`define DCCR_CONSTS_VH

`define DCCR_OFS_CFGWORD3    5'h00
`define DCCR_OFS_CTRL        5'h04
`define DCCR_OFS_IDENT       5'h08
`define DCCR_OFS_UNLOCK      5'h0c
`define DCCR_OFS_PINSEL      5'h10
`define DCCR_OFS_MODDIS      5'h14
`define DCCR_OFS_STATUS      5'h18
`define DCCR_ADDR_W          5

`define DCCR_CW_USB_OWNER    30
`define DCCR_CW_PS_ONCE      29
`define DCCR_CW_MD_ONCE      28
`define DCCR_CW_I2C2_ALT     23
`define DCCR_CW_I2C1_ALT     22
`define DCCR_CW_RSVD_MASK    32'h8f3f0000
`define DCCR_CW_RESET        32'hffffffff

`define DCCR_CC_PS_LOCK      13
`define DCCR_CC_MD_LOCK      12
`define DCCR_CC_LP_FLASH     8
`define DCCR_CC_JTAG_EN      3
`define DCCR_CC_TDO_USE      0
`define DCCR_CC_WR_MASK      32'h00003109
`define DCCR_CC_RESET        32'h00000109

`define DCCR_KEY1            32'haa996655
`define DCCR_KEY2            32'h556699aa
`define DCCR_UNLOCK_WINDOW   8'h20

`define DCCR_ID_DEFAULT      32'h10000001
`define DCCR_PINSEL_RESET    32'h00000000
`define DCCR_MODDIS_RESET    32'h00000000

`endif

// ### core/dccr_unlock.v
// Two-key unlock sequencer: opens a short write window for the lock bits.
// Assumes single-cycle write strobes on sys_clk with their data.
`timescale 1ns/1ps
`include "dccr_consts.vh"

module dccr_unlock (
    sys_clk,
    sys_rst,
    key_wr,
    key_data,
    relock,
    unlocked
);
    input  wire        sys_clk;
    input  wire        sys_rst;
    input  wire        key_wr;
    input  wire [31:0] key_data;
    input  wire        relock;
    output wire        unlocked;

    localparam ST_IDLE = 2'h0;
    localparam ST_KEY1 = 2'h1;
    localparam ST_OPEN = 2'h2;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [7:0] win_q;
    reg [7:0] win_d;

    always @* begin
        state_d = state_q;
        win_d   = win_q;
        case (state_q)
            ST_IDLE: begin
                if (key_wr && key_data == `DCCR_KEY1)
                    state_d = ST_KEY1;
            end
            ST_KEY1: begin
                if (key_wr) begin
                    if (key_data == `DCCR_KEY2) begin
                        state_d = ST_OPEN;
                        win_d   = `DCCR_UNLOCK_WINDOW;
                    end else begin
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_OPEN: begin
                // Window closes on timeout, on a write that changes a lock bit, or on any further key write
                if (relock || win_q == 8'h00 || key_wr)
                    state_d = ST_IDLE;
                else
                    win_d = win_q - 8'h01;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            win_q   <= 8'h00;
        end else begin
            state_q <= state_d;
            win_q   <= win_d;
        end
    end

    assign unlocked = (state_q == ST_OPEN);
endmodule // dccr_unlock

// ### core/dccr_regs.v
// Device configuration/control register bank on an Avalon-MM slave.
// Assumes config word comes from nonvolatile storage via cw_load strobe.
// Operation
// [R1] usb_id_pin_owner 1 gives identity pin to USB, 0 to port logic
// [R2] pin_select_single_config 1 allows one pin-select reconfiguration only
// [R3] module_disable_single_config 1 allows one module-disable reconfig
// [R4] Programmer writes ones to reserved config word bits
// [R5] i2c_port2_alt_select 1 uses primary pins, 0 alternate pins
// [R6] i2c_port1_alt_select 1 uses primary pins, 0 alternate pins
// [R7] 16-bit user tag; software reads it only without code protection
// [R8] pin_select_lock 1 blocks pin-select writes; resets to 0
// [R9] module_disable_lock 1 blocks module-disable writes; resets to 0
// [R10] Lock bits change only after the unlock sequence completes
// [R11] low_power_flash_read 1 enables low-power read circuit; resets 1
// [R12] jtag_port_enable 1 enables JTAG port; resets 1
// [R13] two_wire_tdo_use 1 makes two-wire JTAG use TDO; resets 1
// [R14] Control register unimplemented bits read zero, ignore writes
// [R15] Identity register read-only: revision 31:28, device code 27:0
// [R16] Locked register writes dropped silently, contents kept
`timescale 1ns/1ps
`include "dccr_consts.vh"

module dccr_regs #(
    parameter [31:0] IDENT_VALUE = `DCCR_ID_DEFAULT // Arbitrary value
) (
    sys_clk,
    sys_rst,
    avs_address,
    avs_read,
    avs_write,
    avs_writedata,
    avs_byteenable,
    avs_readdata,
    avs_waitrequest,
    avs_response,
    cw_load,
    cw_data,
    code_protect,
    usb_id_owner_usb,
    i2c2_use_primary,
    i2c1_use_primary,
    user_tag,
    pin_select,
    module_disable,
    low_power_flash_read,
    jtag_port_enable,
    two_wire_tdo_use
);
    input  wire                     sys_clk;
    input  wire                     sys_rst;
    input  wire [`DCCR_ADDR_W-1:0]  avs_address;
    input  wire                     avs_read;
    input  wire                     avs_write;
    input  wire [31:0]              avs_writedata;
    input  wire [3:0]               avs_byteenable;
    output reg  [31:0]              avs_readdata;
    output wire                     avs_waitrequest;
    output reg  [1:0]               avs_response;
    input  wire                     cw_load;
    input  wire [31:0]              cw_data;
    input  wire                     code_protect;
    output wire                     usb_id_owner_usb;
    output wire                     i2c2_use_primary;
    output wire                     i2c1_use_primary;
    output wire [15:0]              user_tag;
    output wire [31:0]              pin_select;
    output wire [31:0]              module_disable;
    output wire                     low_power_flash_read;
    output wire                     jtag_port_enable;
    output wire                     two_wire_tdo_use;

    reg  [31:0] cw_q;
    reg  [31:0] ctrl_q;
    reg  [31:0] ps_q;
    reg  [31:0] md_q;
    reg         ps_done_q;
    reg         md_done_q;
    reg         ack_q;
    reg         prot_s1_q;
    reg         prot_q;
    wire [31:0] wmask;
    reg  [31:0] rd_d;
    reg         err_d;
    wire        unlocked;
    wire        req;
    wire        wr_go;
    wire        ps_blocked;
    wire        md_blocked;
    wire        lock_chg;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_be
            assign wmask[gi*8+7:gi*8] = {8{avs_byteenable[gi]}};
        end
    endgenerate

    // One wait cycle per access; answer at the second edge
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    // Writes land at the edge where waitrequest is seen low
    assign wr_go           = avs_write & ack_q;

    wire key_wr = wr_go && avs_address == `DCCR_OFS_UNLOCK;
    wire ctrl_wr = wr_go && avs_address == `DCCR_OFS_CTRL;
    wire [31:0] ctrl_new = (ctrl_q & ~wmask) | (avs_writedata & wmask);

    // Locks move only inside the unlock window
    assign lock_chg = ctrl_wr && unlocked &&
        ((ctrl_new[`DCCR_CC_PS_LOCK] != ctrl_q[`DCCR_CC_PS_LOCK]) ||
         (ctrl_new[`DCCR_CC_MD_LOCK] != ctrl_q[`DCCR_CC_MD_LOCK])); // [R10]

    // A set lock bit blocks writes to its select register in every mode
    assign ps_blocked = ctrl_q[`DCCR_CC_PS_LOCK]; // [R8]
    assign md_blocked = ctrl_q[`DCCR_CC_MD_LOCK]; // [R9]

    dccr_unlock u_unlock (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .key_wr   (key_wr),
        .key_data (avs_writedata),
        .relock   (lock_chg),
        .unlocked (unlocked)
    );

    // Code protect comes from outside the bus domain
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            prot_s1_q <= 1'b1;
            prot_q    <= 1'b1;
        end else begin
            prot_s1_q <= code_protect;
            prot_q    <= prot_s1_q;
        end
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            ack_q     <= 1'b0;
            cw_q      <= `DCCR_CW_RESET;
            ctrl_q    <= `DCCR_CC_RESET; // [R11] [R12] [R13]
            ps_q      <= `DCCR_PINSEL_RESET;
            md_q      <= `DCCR_MODDIS_RESET;
            ps_done_q <= 1'b0;
            md_done_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
            // Reserved positions kept at one whatever the loader sends
            if (cw_load)
                cw_q <= cw_data | `DCCR_CW_RSVD_MASK; // [R4]
            if (ctrl_wr) begin
                // Plain bits always writable; unimplemented stay zero
                ctrl_q[`DCCR_CC_LP_FLASH] <= ctrl_new[`DCCR_CC_LP_FLASH];
                ctrl_q[`DCCR_CC_JTAG_EN]  <= ctrl_new[`DCCR_CC_JTAG_EN];
                ctrl_q[`DCCR_CC_TDO_USE]  <= ctrl_new[`DCCR_CC_TDO_USE];
                if (unlocked) begin // [R10]
                    // Once-only mode refuses unlocking after first lock
                    if (!(cw_q[`DCCR_CW_PS_ONCE] && ps_done_q &&
                          !ctrl_new[`DCCR_CC_PS_LOCK])) // [R2]
                        ctrl_q[`DCCR_CC_PS_LOCK] <=
                            ctrl_new[`DCCR_CC_PS_LOCK];
                    if (!(cw_q[`DCCR_CW_MD_ONCE] && md_done_q &&
                          !ctrl_new[`DCCR_CC_MD_LOCK])) // [R3]
                        ctrl_q[`DCCR_CC_MD_LOCK] <=
                            ctrl_new[`DCCR_CC_MD_LOCK];
                end
            end
            if (ctrl_q[`DCCR_CC_PS_LOCK])
                ps_done_q <= 1'b1; // [R2]
            if (ctrl_q[`DCCR_CC_MD_LOCK])
                md_done_q <= 1'b1; // [R3]
            if (wr_go && avs_address == `DCCR_OFS_PINSEL && !ps_blocked)
                ps_q <= (ps_q & ~wmask) | (avs_writedata & wmask); // [R16]
            if (wr_go && avs_address == `DCCR_OFS_MODDIS && !md_blocked)
                md_q <= (md_q & ~wmask) | (avs_writedata & wmask); // [R16]
        end
    end

    always @* begin
        rd_d  = 32'h00000000;
        err_d = 1'b0;
        case (avs_address)
            `DCCR_OFS_CFGWORD3:
                rd_d = prot_q ? (cw_q & 32'hffff0000) : cw_q; // [R7]
            `DCCR_OFS_CTRL:   rd_d = ctrl_q & `DCCR_CC_WR_MASK; // [R14]
            `DCCR_OFS_IDENT:  rd_d = IDENT_VALUE; // [R15]
            `DCCR_OFS_UNLOCK: rd_d = 32'h00000000;
            `DCCR_OFS_PINSEL: rd_d = ps_q;
            `DCCR_OFS_MODDIS: rd_d = md_q;
            `DCCR_OFS_STATUS: rd_d = {28'h0000000, md_done_q, ps_done_q,
                                      prot_q, unlocked};
            default:          err_d = 1'b1;
        endcase
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            avs_readdata <= 32'h00000000;
            avs_response <= 2'h0;
        end else if (req & ~ack_q) begin
            avs_readdata <= avs_read ? rd_d : 32'h00000000;
            avs_response <= err_d ? 2'h3 : 2'h0;
        end
    end

    assign usb_id_owner_usb     = cw_q[`DCCR_CW_USB_OWNER]; // [R1]
    assign i2c2_use_primary     = cw_q[`DCCR_CW_I2C2_ALT]; // [R5]
    assign i2c1_use_primary     = cw_q[`DCCR_CW_I2C1_ALT]; // [R6]
    assign user_tag             = cw_q[15:0]; // [R7]
    assign pin_select           = ps_q;
    assign module_disable       = md_q;
    assign low_power_flash_read = ctrl_q[`DCCR_CC_LP_FLASH]; // [R11]
    assign jtag_port_enable     = ctrl_q[`DCCR_CC_JTAG_EN]; // [R12]
    assign two_wire_tdo_use     = ctrl_q[`DCCR_CC_TDO_USE]; // [R13]
endmodule // dccr_regs

// ### bench/dccr_regs_assertions.sv
// Checker for the config/control bank: bus timing and field mapping.
// Bound to dccr_regs below; sees only the bank's ports.
`timescale 1ns/1ps
`include "dccr_consts.vh"

module dccr_regs_chk #(
    parameter [31:0] IDENT_VALUE = `DCCR_ID_DEFAULT
) (
    input wire        sys_clk,
    input wire        sys_rst,
    input wire [4:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire [1:0]  avs_response,
    input wire        cw_load,
    input wire [31:0] cw_data,
    input wire        usb_id_owner_usb,
    input wire        i2c2_use_primary,
    input wire        i2c1_use_primary,
    input wire [31:0] pin_select,
    input wire [31:0] module_disable
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire req     = avs_read || avs_write;
    wire rd_done = avs_read && !avs_waitrequest;
    wire wr_done = avs_write && !avs_waitrequest;

    chk_first_wait: assert property ($rose(req) |-> avs_waitrequest)
        else $error("request answered without a wait cycle");
    chk_one_wait: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("request waited more than one cycle");
    chk_usb_owner: assert property (
        cw_load |=> usb_id_owner_usb == $past(cw_data[30]))
        else $error("usb owner not taken from config word");
    chk_i2c_pins: assert property (
        cw_load |=> {i2c2_use_primary, i2c1_use_primary} ==
                    $past(cw_data[23:22]))
        else $error("i2c pin selects not taken from config word");
    chk_cw_steady: assert property (
        !cw_load |=> $stable({usb_id_owner_usb, i2c2_use_primary,
                              i2c1_use_primary}))
        else $error("config word outputs moved without a load");
    chk_ctrl_unimpl: assert property (
        rd_done && avs_address == 5'h04 |->
            (avs_readdata & ~32'h3109) == 32'h0)
        else $error("unimplemented control bits read nonzero");
    chk_ident_value: assert property (
        rd_done && avs_address == 5'h08 |-> avs_readdata == IDENT_VALUE)
        else $error("identity register read wrong value");
    chk_pinsel_hold: assert property (
        $changed(pin_select) |-> $past(wr_done && avs_address == 5'h10))
        else $error("pin select changed without its write");
    chk_moddis_hold: assert property (
        $changed(module_disable) |-> $past(wr_done && avs_address == 5'h14))
        else $error("module disable changed without its write");
    chk_decode_err: assert property (
        (rd_done || wr_done) && avs_address > 5'h18 |-> avs_response == 2'h3)
        else $error("unmapped access not flagged");

    cover property (cw_load);
    cover property (wr_done && avs_address == 5'h04);
    cover property (avs_response == 2'h3);
endmodule // dccr_regs_chk

bind dccr_regs dccr_regs_chk #(.IDENT_VALUE(IDENT_VALUE)) u_chk (
    .sys_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .avs_response, .cw_load, .cw_data, .usb_id_owner_usb,
    .i2c2_use_primary, .i2c1_use_primary, .pin_select, .module_disable);

// ### bench/device_config_control_regs_tb.sv
// Self-checking bench for the config/control bank with a register model.
// Drives the Avalon-MM slave and the config word load port directly.
`timescale 1ns/1ps
`include "dccr_consts.vh"

module device_config_control_regs_tb;
    logic        sys_clk, sys_rst, avs_read, avs_write, cw_load, code_protect;
    logic        avs_waitrequest, usb_id_owner_usb, i2c2_use_primary;
    logic        i2c1_use_primary, low_power_flash_read, jtag_port_enable;
    logic        two_wire_tdo_use;
    logic [4:0]  avs_address, a;
    logic [3:0]  avs_byteenable;
    logic [1:0]  avs_response, resp;
    logic [15:0] user_tag;
    logic [31:0] avs_writedata, avs_readdata, cw_data, pin_select;
    logic [31:0] module_disable, rdata, d, ctrl_m, cw_m;
    logic [31:0] reg_m [2];
    int          miscompares, check_count;
    wire  [18:0] cw_outs = {usb_id_owner_usb, i2c2_use_primary,
                            i2c1_use_primary, user_tag};
    wire  [8:0]  ctrl_outs = {low_power_flash_read, 4'h0, jtag_port_enable,
                              2'h0, two_wire_tdo_use};

    dccr_regs u_dut (.sys_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .avs_response, .cw_load, .cw_data, .code_protect, .usb_id_owner_usb,
        .i2c2_use_primary, .i2c1_use_primary, .user_tag, .pin_select,
        .module_disable, .low_power_flash_read, .jtag_port_enable,
        .two_wire_tdo_use);

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Idle edge first, so a release and the next request never share a step
    task automatic bus(input logic wr, input logic [4:0] ad,
                       input logic [31:0] wd);
        int n;
        @(posedge sys_clk);
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= ad;
        avs_writedata <= wd;
        n = 0;
        // Sampled at the edge: values still those of the closing cycle
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        if (avs_waitrequest !== 1'b0) chk("waitrequest", 1, 0);
        rdata = avs_readdata;
        resp = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic rdc(input string nm, input logic [4:0] ad,
                       input logic [31:0] e);
        bus(1'b0, ad, 32'h0);
        chk(nm, rdata, e);
        chk("response", resp, (ad > 5'h18) ? 2'h3 : 2'h0);
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk);
        chk("watchdog", 1, 0);
        conclude();
    end

    initial begin
        {sys_rst, avs_read, avs_write, cw_load, code_protect} = 5'h10;
        avs_address = 5'h0;
        avs_writedata = 32'h0;
        cw_data = 32'h0;
        avs_byteenable = 4'hf;
        miscompares = 0;
        check_count = 0;
        void'($urandom(32'h63d49961));
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rdc("ctrl_reset", 5'h04, 32'h109);
        rdc("ident", 5'h08, `DCCR_ID_DEFAULT);
        repeat (3) begin
            @(posedge sys_clk);
            cw_data <= $urandom | 32'h8f3f0000;
            cw_load <= 1'b1;
            @(posedge sys_clk);
            cw_load <= 1'b0;
            @(negedge sys_clk);
            // Reserved positions always come back as ones
            cw_m = cw_data | 32'h8f3f0000;
            d = {cw_m[30], cw_m[23:22], cw_m[15:0]};
            chk("cw_outs", cw_outs, d);
            rdc("cw_read", 5'h00, cw_m);
        end
        @(posedge sys_clk);
        code_protect <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rdc("cw_hidden", 5'h00, cw_m & 32'hffff0000);
        code_protect <= 1'b0;
        repeat (3) begin
            d = $urandom;
            bus(1'b1, 5'h04, d);
            ctrl_m = d & 32'h109;
            rdc("ctrl_nolock", 5'h04, ctrl_m);
            chk("ctrl_outs", ctrl_outs, ctrl_m[8:0]);
        end
        bus(1'b1, 5'h08, d);
        rdc("ident_ro", 5'h08, `DCCR_ID_DEFAULT);
        bus(1'b1, 5'h1c, d);
        rdc("unmapped", 5'h1c, 32'h0);
        for (int i = 0; i < 2; i++) begin
            a = (i == 0) ? 5'h10 : 5'h14;
            reg_m[i] = $urandom;
            bus(1'b1, a, reg_m[i]);
            rdc("sel_open", a, reg_m[i]);
        end
        // A stray write between the keys must cancel the sequence
        bus(1'b1, 5'h0c, `DCCR_KEY1);
        bus(1'b1, 5'h0c, 32'h0);
        bus(1'b1, 5'h0c, `DCCR_KEY2);
        bus(1'b1, 5'h04, ctrl_m | 32'h3000);
        rdc("broken_key", 5'h04, ctrl_m);
        bus(1'b1, 5'h0c, `DCCR_KEY1);
        bus(1'b1, 5'h0c, `DCCR_KEY2);
        ctrl_m = ctrl_m | 32'h3000;
        bus(1'b1, 5'h04, ctrl_m);
        rdc("ctrl_locked", 5'h04, ctrl_m);
        for (int i = 0; i < 2; i++) begin
            a = (i == 0) ? 5'h10 : 5'h14;
            bus(1'b1, a, ~reg_m[i]);
            chk("lock_resp", resp, 2'h0);
            rdc("sel_kept", a, reg_m[i]);
        end
        chk("ps_out", pin_select, reg_m[0]);
        chk("md_out", module_disable, reg_m[1]);
        bus(1'b1, 5'h04, ctrl_m & 32'h109);
        rdc("lock_stays", 5'h04, ctrl_m);
        // Once-only pin select keeps its lock; module disable may reopen
        @(posedge sys_clk);
        cw_data <= ($urandom | 32'haf3f0000) & 32'hefffffff;
        cw_load <= 1'b1;
        @(posedge sys_clk);
        cw_load <= 1'b0;
        bus(1'b1, 5'h0c, `DCCR_KEY1);
        bus(1'b1, 5'h0c, `DCCR_KEY2);
        bus(1'b1, 5'h04, 32'h0);
        rdc("once_only", 5'h04, 32'h2000);
        bus(1'b1, 5'h14, ~reg_m[1]);
        rdc("md_reopen", 5'h14, ~reg_m[1]);
        bus(1'b1, 5'h10, ~reg_m[0]);
        rdc("ps_once", 5'h10, reg_m[0]);
        chk("md_out2", module_disable, ~reg_m[1]);
        conclude();
    end
endmodule // device_config_control_regs_tb
